/* common/ipc_pkg.sv */
// Package for the interrupt priority and control register block.
// Assumes a 10 MHz ref_clk and an APB master with 32-bit data.
package ipc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets.
    // ------------------------------------------------------------
    localparam logic [7:0] IPC_OFS_STATUS = 8'h00;
    localparam logic [7:0] IPC_OFS_CORE = 8'h04;
    localparam logic [7:0] IPC_OFS_CTRL1 = 8'h08;
    localparam logic [7:0] IPC_OFS_CTRL2 = 8'h0C;
    localparam logic [7:0] IPC_OFS_FLAG0 = 8'h10;
    localparam logic [7:0] IPC_OFS_ENABLE0 = 8'h14;
    localparam logic [7:0] IPC_OFS_PRIO0 = 8'h18;
    localparam logic [7:0] IPC_OFS_PRIO1 = 8'h1C;
    localparam logic [7:0] IPC_OFS_PRIO2 = 8'h20;
    localparam logic [7:0] IPC_OFS_PRIO3 = 8'h24;
    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int IPC_SR_PRIO_LSB = 5;
    localparam int IPC_CORE_TOP_BIT = 3;
    localparam int IPC_C1_NEST_DIS = 15;
    localparam int IPC_C1_OVA = 14;
    localparam int IPC_C1_OVB = 13;
    localparam int IPC_C1_COVA = 12;
    localparam int IPC_C1_COVB = 11;
    localparam int IPC_C1_ACC_A_OVERFLOW_TRAP_EN = 10;
    localparam int IPC_C1_ACC_B_OVERFLOW_TRAP_EN = 9;
    localparam int IPC_C1_CATASTROPHIC_TRAP_EN = 8;
    localparam int IPC_C1_SHIFT = 7;
    localparam int IPC_C1_DIV0 = 6;
    localparam int IPC_C1_DMA = 5;
    localparam int IPC_C1_MATH = 4;
    localparam int IPC_C1_ADDR = 3;
    localparam int IPC_C1_STACK = 2;
    localparam int IPC_C1_OSC = 1;
    localparam int IPC_C2_ALT = 15;
    localparam int IPC_C2_HOLD = 14;
    localparam int IPC_NUM_SRC = 15;
    // ------------------------------------------------------------
    // Writable masks and reset values.
    // ------------------------------------------------------------
    localparam logic [15:0] IPC_C1_TRAP_MASK = 16'h7EFE;
    localparam logic [15:0] IPC_C1_WR_MASK = 16'hFFFE;
    localparam logic [15:0] IPC_C2_WR_MASK = 16'h8007;
    localparam logic [15:0] IPC_FLAG_MASK = 16'h7FFF;
    localparam logic [2:0] IPC_PRIO_RESET = 3'h0;
    localparam logic [2:0] IPC_PRIO_MAX = 3'h7;
    localparam logic [15:0] IPC_REG_RESET = 16'h0000;
    localparam logic [59:0] IPC_SRC_PRIO_RESET = 60'h0;
    localparam logic [31:0] IPC_RD_UNMAPPED = 32'h0000_0000;
endpackage

/* hdl/ipc_edge_detect.sv */
// Selectable edge detector for one external interrupt input.
// Assumes the input is already synchronous to ref_clk.
`timescale 1ns/1ns
module ipc_edge_detect (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Pin and polarity.
    input wire logic pin,
    input wire logic neg_edge,
    // Detected edge.
    output logic hit
);
    logic prev_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prev_q <= pin;
        end else begin
            prev_q <= pin;
        end
    end

    // Reset tracks the pin level, so a pin already high at release gives no false edge.
    assign hit = neg_edge ? (prev_q & ~pin) : (~prev_q & pin);
endmodule

/* hdl/ipc_regs.sv */
// Interrupt priority, global control and first flag register block.
// Assumes an APB master, synchronous trap strobes and peripheral pulses.
`timescale 1ns/1ns
module ipc_regs
    import ipc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trap events from the core, one-cycle pulses, and the irq_hold_active level.
    input wire logic acc_a_overflow,
    input wire logic acc_b_overflow,
    input wire logic acc_a_catastrophic,
    input wire logic acc_b_catastrophic,
    input wire logic bad_shift,
    input wire logic divide_zero,
    input wire logic dma_fault,
    input wire logic address_fault,
    input wire logic stack_fault,
    input wire logic osc_fail,
    input wire logic irq_hold_active,
    // Interrupt sources.
    input wire logic [2:0] ext_pin,
    input wire logic [IPC_NUM_SRC-1:0] periph_req,
    // Outputs to the CPU.
    output logic [3:0] cpu_level,
    output logic user_irq_blocked,
    output logic trap_pending,
    output logic alt_vector_select,
    output logic nesting_disable,
    output logic irq_request,
    output logic [3:0] irq_source,
    output logic [2:0] irq_level
);
    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    logic [2:0] cpu_prio_low_field_q;
    logic cpu_prio_top_bit_q;
    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic [15:0] flag0_q;
    logic [15:0] enable0_q;
    logic [59:0] src_prio_q;
    logic [31:0] prdata_q;
    logic [2:0] ext_hit;
    logic [15:0] wdata16;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [15:0] trap_set;
    logic any_trap;
    logic [IPC_NUM_SRC-1:0] flag_set;
    logic [IPC_NUM_SRC-1:0] req_in;
    logic [3:0] best_src;
    logic [2:0] best_prio;
    logic best_valid;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign wdata16 = pwdata[15:0];
    assign addr_ok = hit(paddr, IPC_OFS_STATUS) | hit(paddr, IPC_OFS_CORE) | hit(paddr, IPC_OFS_CTRL1)
        | hit(paddr, IPC_OFS_CTRL2) | hit(paddr, IPC_OFS_FLAG0) | hit(paddr, IPC_OFS_ENABLE0)
        | hit(paddr, IPC_OFS_PRIO0) | hit(paddr, IPC_OFS_PRIO1) | hit(paddr, IPC_OFS_PRIO2)
        | hit(paddr, IPC_OFS_PRIO3);
    // Zero wait states keep the bus simple; the error flag marks holes in the map.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // External edge detectors.
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ext
            ipc_edge_detect u_edge (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .pin(ext_pin[g]),
                .neg_edge(ctrl2_q[g]),
                .hit(ext_hit[g])
            );
        end
    endgenerate

    // Source 0 is external interrupt 0; the others arrive as peripheral pulses.
    assign req_in = {periph_req[IPC_NUM_SRC-1:1], ext_hit[0]};

    // ------------------------------------------------------------
    // Trap flag sources.
    // ------------------------------------------------------------
    always_comb begin
        trap_set = 16'h0000;
        trap_set[IPC_C1_OVA] = acc_a_overflow & ctrl1_q[IPC_C1_ACC_A_OVERFLOW_TRAP_EN];
        trap_set[IPC_C1_OVB] = acc_b_overflow & ctrl1_q[IPC_C1_ACC_B_OVERFLOW_TRAP_EN];
        trap_set[IPC_C1_COVA] = acc_a_catastrophic & ctrl1_q[IPC_C1_CATASTROPHIC_TRAP_EN];
        trap_set[IPC_C1_COVB] = acc_b_catastrophic & ctrl1_q[IPC_C1_CATASTROPHIC_TRAP_EN];
        trap_set[IPC_C1_SHIFT] = bad_shift;
        trap_set[IPC_C1_DIV0] = divide_zero;
        trap_set[IPC_C1_MATH] = bad_shift | divide_zero;
        trap_set[IPC_C1_DMA] = dma_fault;
        trap_set[IPC_C1_ADDR] = address_fault;
        trap_set[IPC_C1_STACK] = stack_fault;
        trap_set[IPC_C1_OSC] = osc_fail;
    end
    assign any_trap = |trap_set;

    // ------------------------------------------------------------
    // Priority field and top bit.
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cpu_prio_low_field_q <= IPC_PRIO_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_STATUS) && !ctrl1_q[IPC_C1_NEST_DIS]) begin
            cpu_prio_low_field_q <= wdata16[IPC_SR_PRIO_LSB +: 3];
        end
    end

    // A trap raises the level above 7; a write may only clear it, and the set wins.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cpu_prio_top_bit_q <= 1'b0;
        end else if (any_trap) begin
            cpu_prio_top_bit_q <= 1'b1;
        end else if (wr_en && hit(paddr, IPC_OFS_CORE) && !wdata16[IPC_CORE_TOP_BIT]) begin
            cpu_prio_top_bit_q <= 1'b0;
        end
    end

    assign cpu_level = {cpu_prio_top_bit_q, cpu_prio_low_field_q};
    assign user_irq_blocked = cpu_prio_top_bit_q | (cpu_prio_low_field_q == IPC_PRIO_MAX);
    assign trap_pending = cpu_prio_top_bit_q;

    // ------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl1_q <= IPC_REG_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_CTRL1)) begin
            ctrl1_q <= (wdata16 & IPC_C1_WR_MASK) | trap_set;
        end else begin
            ctrl1_q <= ctrl1_q | trap_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl2_q <= IPC_REG_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_CTRL2)) begin
            ctrl2_q <= wdata16 & IPC_C2_WR_MASK;
        end
    end

    assign nesting_disable = ctrl1_q[IPC_C1_NEST_DIS];
    assign alt_vector_select = ctrl2_q[IPC_C2_ALT];

    // ------------------------------------------------------------
    // Flags, enables and source priorities.
    // ------------------------------------------------------------
    assign flag_set = req_in;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            flag0_q <= IPC_REG_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_FLAG0)) begin
            flag0_q <= (wdata16 | {1'b0, flag_set}) & IPC_FLAG_MASK;
        end else begin
            flag0_q <= flag0_q | {1'b0, flag_set};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            enable0_q <= IPC_REG_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_ENABLE0)) begin
            enable0_q <= wdata16 & IPC_FLAG_MASK;
        end
    end

    // Word w holds sources 4w to 4w+3 in vector order, three bits each in the low nibbles.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            src_prio_q <= IPC_SRC_PRIO_RESET;
        end else if (wr_en && hit(paddr, IPC_OFS_PRIO0)) begin
            src_prio_q[11:0] <= {wdata16[14:12], wdata16[10:8], wdata16[6:4], wdata16[2:0]};
        end else if (wr_en && hit(paddr, IPC_OFS_PRIO1)) begin
            src_prio_q[23:12] <= {wdata16[14:12], wdata16[10:8], wdata16[6:4], wdata16[2:0]};
        end else if (wr_en && hit(paddr, IPC_OFS_PRIO2)) begin
            src_prio_q[35:24] <= {wdata16[14:12], wdata16[10:8], wdata16[6:4], wdata16[2:0]};
        end else if (wr_en && hit(paddr, IPC_OFS_PRIO3)) begin
            src_prio_q[47:36] <= {wdata16[14:12], wdata16[10:8], wdata16[6:4], wdata16[2:0]};
        end
    end

    // ------------------------------------------------------------
    // Arbitration: highest priority wins, lowest source index breaks ties.
    // ------------------------------------------------------------
    always_comb begin
        best_src = 4'h0;
        best_prio = 3'h0;
        best_valid = 1'b0;
        for (int i = IPC_NUM_SRC - 1; i >= 0; i--) begin
            if (flag0_q[i] && enable0_q[i] && (!best_valid || src_prio_q[3*i +: 3] >= best_prio)) begin
                best_src = 4'(i);
                best_prio = src_prio_q[3*i +: 3];
                best_valid = 1'b1;
            end
        end
    end

    // Level 0 is above no CPU level, so a source at 0 is effectively off.
    assign irq_request = best_valid && ({1'b0, best_prio} > cpu_level);
    assign irq_source = best_src;
    assign irq_level = best_prio;

    // ------------------------------------------------------------
    // Read data, captured in the setup phase.
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            prdata_q <= IPC_RD_UNMAPPED;
        end else if (rd_en) begin
            prdata_q <= IPC_RD_UNMAPPED;
            if (hit(paddr, IPC_OFS_STATUS)) begin
                prdata_q[IPC_SR_PRIO_LSB +: 3] <= cpu_prio_low_field_q;
            end
            if (hit(paddr, IPC_OFS_CORE)) begin
                prdata_q[IPC_CORE_TOP_BIT] <= cpu_prio_top_bit_q;
            end
            if (hit(paddr, IPC_OFS_CTRL1)) begin
                prdata_q[15:0] <= ctrl1_q;
            end
            if (hit(paddr, IPC_OFS_CTRL2)) begin
                prdata_q[15:0] <= ctrl2_q | {1'b0, irq_hold_active, 14'h0};
            end
            if (hit(paddr, IPC_OFS_FLAG0)) begin
                prdata_q[15:0] <= flag0_q;
            end
            if (hit(paddr, IPC_OFS_ENABLE0)) begin
                prdata_q[15:0] <= enable0_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    sequence s_trap_event;
        any_trap;
    endsequence

    sequence s_top_set;
        ##1 cpu_prio_top_bit_q;
    endsequence

    a_trap_raises_level: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_trap_event |-> s_top_set) else $error("trap did not raise top priority bit");

    a_prio_locked_nest: assert property (@(posedge ref_clk) disable iff (!rstn)
        ctrl1_q[IPC_C1_NEST_DIS] |=> $stable(cpu_prio_low_field_q))
        else $error("priority field changed while nesting disabled");

    a_block_at_top: assert property (@(posedge ref_clk) disable iff (!rstn)
        user_irq_blocked |-> !irq_request) else $error("request passed while blocked");

    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
        (flag0_q[0] && !wr_en) |=> flag0_q[0]) else $error("flag dropped without a write");

    a_flag_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
        periph_req[3] |=> flag0_q[3]) else $error("peripheral request lost");

    a_ovf_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!ctrl1_q[IPC_C1_ACC_A_OVERFLOW_TRAP_EN] && !ctrl1_q[IPC_C1_OVA] && !wr_en) |=> !ctrl1_q[IPC_C1_OVA])
        else $error("disabled overflow trap flagged");

    a_math_summary: assert property (@(posedge ref_clk) disable iff (!rstn)
        divide_zero |=> (ctrl1_q[IPC_C1_DIV0] && ctrl1_q[IPC_C1_MATH]))
        else $error("math trap flags not set");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        !ctrl1_q[0] && !flag0_q[15] && (ctrl2_q[13:3] == 11'h0)) else $error("reserved bit set");

    a_level_compare: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_request |-> ({1'b0, irq_level} > cpu_level) && !cpu_level[3])
        else $error("request not above cpu level");
endmodule

/* dv/ipc_src_model.sv */
// Model of the core trap logic and the interrupt sources beside the block.
// Assumes the bench calls its tasks and that every output is a level or pulse on ref_clk.
`timescale 1ns/1ns
module ipc_src_model (
    // Clock.
    input wire logic ref_clk,
    // Events toward the block.
    output logic [9:0] trap,
    output logic [14:0] req,
    output logic [2:0] ext,
    output logic hold
);
    // ------------------------------------------------------------
    // Event drivers.
    // ------------------------------------------------------------
    initial begin
        trap = 10'h000;
        req = 15'h0000;
        ext = 3'h0;
        hold = 1'b0;
    end

    // One-cycle trap pulse; spare edges let the flag land before a read.
    task automatic fire_trap(input int i);
        @(posedge ref_clk);
        trap[i] <= 1'b1;
        @(posedge ref_clk);
        trap[i] <= 1'b0;
        @(posedge ref_clk);
    endtask

    // A request is one pulse; clearing is left to software.
    task automatic fire_req(input int i);
        @(posedge ref_clk);
        req[i] <= 1'b1;
        @(posedge ref_clk);
        req[i] <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Pin changes are held long enough for detection and the flag update.
    task automatic set_ext(input int i, input logic v);
        @(posedge ref_clk);
        ext[i] <= v;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic set_hold(input logic v);
        @(posedge ref_clk);
        hold <= v;
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the interrupt priority and control register block.
// Assumes ipc_src_model drives the event inputs and APB runs on ref_clk.
`timescale 1ns/1ns
module tb
    import ipc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, hold;
    logic [9:0] trap;
    logic [14:0] req;
    logic [2:0] ext, irq_level;
    logic [3:0] cpu_level, irq_source;
    logic user_irq_blocked, trap_pending, alt_vector_select, nesting_disable, irq_request;
    int n_mismatch = 0;
    int tests_run = 0;
    localparam logic [15:0] TRAP_BIT [10] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800,
        16'h0090, 16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

    always #50 ref_clk = ~ref_clk;

    ipc_src_model src (.ref_clk(ref_clk), .trap(trap), .req(req), .ext(ext), .hold(hold));

    ipc_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_a_overflow(trap[0]), .acc_b_overflow(trap[1]),
        .acc_a_catastrophic(trap[2]), .acc_b_catastrophic(trap[3]), .bad_shift(trap[4]),
        .divide_zero(trap[5]), .dma_fault(trap[6]), .address_fault(trap[7]),
        .stack_fault(trap[8]), .osc_fail(trap[9]), .irq_hold_active(hold), .ext_pin(ext),
        .periph_req(req), .cpu_level(cpu_level), .user_irq_blocked(user_irq_blocked),
        .trap_pending(trap_pending), .alt_vector_select(alt_vector_select),
        .nesting_disable(nesting_disable), .irq_request(irq_request),
        .irq_source(irq_source), .irq_level(irq_level));

    // ------------------------------------------------------------
    // Bus cycles and comparisons.
    // ------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
        chk_reg({28'h0000000, got}, {28'h0000000, exp});
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h00000000, got}, {31'h00000000, exp});
    endtask

    // The wait has no limit of its own; the watchdog ends a slave that never answers.
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000);
        chk_reg(rd, exp);
    endtask

    task automatic settle;
        @(posedge ref_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_chk(IPC_OFS_STATUS, 32'h0000_0000);
        rd_chk(IPC_OFS_CORE, 32'h0000_0000);
        rd_chk(IPC_OFS_CTRL1, 32'h0000_0000);
        rd_chk(IPC_OFS_CTRL2, 32'h0000_0000);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0000);
        apb(1'b0, 8'h40, 16'h0000);
        chk_reg(rd, IPC_RD_UNMAPPED);
        chk_bit(err, 1'b1);
    endtask

    task automatic t_level;
        wr(IPC_OFS_STATUS, 16'hFFFF);
        rd_chk(IPC_OFS_STATUS, 32'h0000_00E0);
        settle;
        chk_val(cpu_level, 4'h7);
        chk_bit(user_irq_blocked, 1'b1);
        wr(IPC_OFS_STATUS, 16'h00C0);
        settle;
        chk_val(cpu_level, 4'h6);
        chk_bit(user_irq_blocked, 1'b0);
    endtask

    task automatic t_nest;
        wr(IPC_OFS_CTRL1, 16'hFFFF);
        rd_chk(IPC_OFS_CTRL1, 32'h0000_FFFE);
        chk_bit(nesting_disable, 1'b1);
        wr(IPC_OFS_STATUS, 16'h0020);
        rd_chk(IPC_OFS_STATUS, 32'h0000_00C0);
        wr(IPC_OFS_CTRL1, 16'h0000);
        wr(IPC_OFS_STATUS, 16'h0020);
        rd_chk(IPC_OFS_STATUS, 32'h0000_0020);
    endtask

    // Overflow traps must stay silent until their enables are set.
    task automatic t_traps;
        for (int i = 0; i < 4; i++) src.fire_trap(i);
        rd_chk(IPC_OFS_CTRL1, 32'h0000_0000);
        chk_bit(trap_pending, 1'b0);
        wr(IPC_OFS_CTRL1, 16'h0700);
        for (int i = 0; i < 10; i++) begin
            src.fire_trap(i);
            rd_chk(IPC_OFS_CTRL1, {16'h0000, 16'h0700 | TRAP_BIT[i]});
            rd_chk(IPC_OFS_CORE, 32'h0000_0008);
            chk_val(cpu_level, 4'h9);
            chk_bit(user_irq_blocked, 1'b1);
            wr(IPC_OFS_CORE, 16'h0000);
            rd_chk(IPC_OFS_CORE, 32'h0000_0000);
            wr(IPC_OFS_CORE, 16'h0008);
            rd_chk(IPC_OFS_CORE, 32'h0000_0000);
            wr(IPC_OFS_CTRL1, 16'h0700);
        end
        wr(IPC_OFS_CTRL1, 16'h0000);
    endtask

    task automatic t_ctrl2;
        wr(IPC_OFS_CTRL2, 16'hFFFF);
        rd_chk(IPC_OFS_CTRL2, 32'h0000_8007);
        chk_bit(alt_vector_select, 1'b1);
        src.set_hold(1'b1);
        rd_chk(IPC_OFS_CTRL2, 32'h0000_C007);
        wr(IPC_OFS_CTRL2, 16'h0000);
        rd_chk(IPC_OFS_CTRL2, 32'h0000_4000);
        chk_bit(alt_vector_select, 1'b0);
        src.set_hold(1'b0);
    endtask

    task automatic t_ext;
        src.set_ext(0, 1'b1);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0001);
        wr(IPC_OFS_FLAG0, 16'h0000);
        src.set_ext(0, 1'b0);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0000);
        wr(IPC_OFS_CTRL2, 16'h0007);
        src.set_ext(0, 1'b1);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0000);
        src.set_ext(0, 1'b0);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0001);
        for (int g = 1; g < 3; g++) src.set_ext(g, 1'b1);
        wr(IPC_OFS_FLAG0, 16'h0000);
        wr(IPC_OFS_CTRL2, 16'h0000);
    endtask

    task automatic t_flags;
        for (int w = 0; w < 4; w++) wr(IPC_OFS_PRIO0 + 8'(4 * w), 16'h7777);
        wr(IPC_OFS_PRIO3, 16'h0710);
        wr(IPC_OFS_ENABLE0, 16'h7FFF);
        wr(IPC_OFS_STATUS, 16'h0000);
        src.fire_req(0);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0000);
        src.fire_req(14);
        repeat (5) settle;
        rd_chk(IPC_OFS_FLAG0, 32'h0000_4000);
        chk_bit(irq_request, 1'b1);
        chk_val(irq_source, 4'hE);
        chk_val({1'b0, irq_level}, 4'h7);
        wr(IPC_OFS_STATUS, 16'h00C0);
        settle;
        chk_bit(irq_request, 1'b1);
        wr(IPC_OFS_STATUS, 16'h00E0);
        settle;
        chk_bit(irq_request, 1'b0);
        wr(IPC_OFS_STATUS, 16'h0000);
        src.fire_req(3);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_4008);
        chk_val(irq_source, 4'h3);
        wr(IPC_OFS_FLAG0, 16'hFFFF);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_7FFF);
        wr(IPC_OFS_FLAG0, 16'h0000);
        rd_chk(IPC_OFS_FLAG0, 32'h0000_0000);
        chk_bit(irq_request, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict.
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset;
        t_level;
        t_nest;
        t_traps;
        t_ctrl2;
        t_ext;
        t_flags;
        finish_test;
    end
endmodule
